//--- sdhp_pkg.sv
// Purpose: shared constants and types for the serial descriptor and hid programming port
// Assumes: 16-bit words, descriptor bits sent lsb first
// Notes: none
package sdhp_pkg;
   localparam int SDHP_WORD_W = 16;
   localparam int SDHP_SEL_BIT = 11;
   localparam int SDHP_PTR_BIT = 9;
   localparam int SDHP_DESC_BITS = 456;
   localparam int SDHP_DESC_BYTES = SDHP_DESC_BITS / 8;
   localparam int SDHP_ADDR_W = 6;
   localparam int SDHP_FIFO_DEPTH = 16;
   localparam logic [7:0] SDHP_HID_RESET = 8'h00;
   localparam logic [3:0] SDHP_TOP_ZERO = 4'h0;

   typedef struct packed {
      logic [SDHP_ADDR_W-1:0] addr;
      logic [7:0] data;
   } sdhp_desc_wr_t;

   typedef enum logic [2:0] {
      SDHP_IDLE = 3'b001,
      SDHP_SHIFT = 3'b010,
      SDHP_DONE = 3'b100
   } sdhp_state_t;
endpackage

//--- sdhp_fifo.sv
// Purpose: small flip-flop fifo with valid/ready on both sides
// Assumes: single clock
// Notes: depth is a power of two
`timescale 1ns/1ps
module sdhp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q, wr_d, rd_q, rd_d;
   logic push, pop;

   always_comb
   begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
   end

   assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_valid = (wr_q != rd_q);
   assign out_data = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wr_q[AW-1:0]] <= in_data;
   end
endmodule // sdhp_fifo

//--- sdhp_port.sv
// Purpose: write-only serial programming port for hid status and descriptor image
// Assumes: serial clock well below core_clk, sampled through two flip-flops
// Notes: descriptor bytes leave through a fifo toward the descriptor store
//
// How it works
// - bit 11 selects hid or descriptor word
// - d7..d4: mute, vol up, vol down, next
// - d3..d0: prev, stop, play, extended
// - descriptor byte stored with d0 as lsb
// - pointer bit clears descriptor address counter in hid words; descriptor words with it set are ignored
// - select low, pointer high: reset and hid
// - descriptor writes and pointer reset only with both enable pins high; hid words taken whatever the pins once 16 bits have arrived
`timescale 1ns/1ps
module sdhp_port
   import sdhp_pkg::*;
#(
   parameter int DESC_BYTES = SDHP_DESC_BYTES,
   parameter int FIFO_DEPTH = SDHP_FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic serial_clock_in,
   input wire logic serial_data_in,
   input wire logic word_select_strobe,
   input wire logic power_source_sel,
   input wire logic descriptor_source_sel,
   output logic [7:0] hid_status,
   output logic hid_update,
   output logic [SDHP_ADDR_W-1:0] desc_addr,
   output logic desc_wr_valid,
   output logic [SDHP_ADDR_W+7:0] desc_wr,
   input wire logic desc_wr_ready,
   output logic desc_complete
);
   // two flops per pin before any logic reads it, a third stage finds edges
   logic [2:0] sck_q, sck_d;
   logic [2:0] sel_q, sel_d;
   logic [1:0] sdi_q, sdi_d;
   logic [SDHP_WORD_W-1:0] shreg_q, shreg_d;
   logic [4:0] cnt_q, cnt_d;
   sdhp_state_t st_q, st_d;
   logic [7:0] hid_q, hid_d;
   logic hid_upd_q, hid_upd_d;
   logic [SDHP_ADDR_W-1:0] addr_q, addr_d;
   logic done_q, done_d;
   logic prog_en_q, prog_en_d;
   logic [1:0] psel_q, psel_d;
   logic [1:0] dsel_q, dsel_d;
   sdhp_desc_wr_t fifo_in;
   logic fifo_in_valid, fifo_in_ready;
   logic [SDHP_ADDR_W+7:0] fifo_out;
   logic fifo_out_valid;
   logic [SDHP_ADDR_W+7:0] dwr_q, dwr_d;
   logic dval_q, dval_d;
   logic sck_rise, sel_rise, sel_fall, word_ok, sel_bit, ptr_bit;

   // bit reversal: word bit 7 carries d0
   function automatic logic [7:0] sdhp_rev8(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++)
         r[i] = v[7-i];
      return r;
   endfunction

   always_comb
   begin
      sck_d = {sck_q[1:0], serial_clock_in};
      sel_d = {sel_q[1:0], word_select_strobe};
      sdi_d = {sdi_q[0], serial_data_in};
      psel_d = {psel_q[0], power_source_sel};
      dsel_d = {dsel_q[0], descriptor_source_sel};
      sck_rise = sck_q[1] && !sck_q[2];
      sel_rise = sel_q[1] && !sel_q[2];
      sel_fall = !sel_q[1] && sel_q[2];
      sel_bit = shreg_q[SDHP_SEL_BIT];
      ptr_bit = shreg_q[SDHP_PTR_BIT];
      word_ok = (cnt_q == 5'(SDHP_WORD_W));
      // each source pin synchronised on its own before they are combined
      prog_en_d = psel_q[1] && dsel_q[1];
      st_d = st_q;
      shreg_d = shreg_q;
      cnt_d = cnt_q;
      hid_d = hid_q;
      hid_upd_d = 1'b0;
      addr_d = addr_q;
      done_d = done_q;
      // next descriptor byte toward the fifo
      fifo_in.addr = addr_q;
      fifo_in.data = sdhp_rev8(shreg_q[7:0]);
      fifo_in_valid = 1'b0;
      case (st_q)
         SDHP_IDLE:
         begin
            if (sel_fall)
            begin
               cnt_d = '0;
               st_d = SDHP_SHIFT;
            end
         end
         SDHP_SHIFT:
         begin
            if (sel_rise)
               st_d = SDHP_DONE;
            else if (sck_rise)
            begin
               shreg_d = {shreg_q[SDHP_WORD_W-2:0], sdi_q[1]};
               if (cnt_q != 5'(SDHP_WORD_W))
                  cnt_d = cnt_q + 5'h01;
            end
         end
         SDHP_DONE:
         begin
            st_d = SDHP_IDLE;
            if (word_ok && !sel_bit)
            begin
               hid_d = sdhp_rev8(shreg_q[7:0]);
               hid_upd_d = 1'b1;
               if (ptr_bit && prog_en_q)
               begin
                  addr_d = '0;
                  done_d = 1'b0;
               end
            end
            else if (word_ok && sel_bit && !ptr_bit && prog_en_q && !done_q)
            begin
               if (fifo_in_ready)
               begin
                  fifo_in_valid = 1'b1;
                  if (addr_q == SDHP_ADDR_W'(DESC_BYTES - 1))
                     done_d = 1'b1;
                  else
                     addr_d = addr_q + 1'b1;
               end
               else
                  // a full fifo holds the byte here until a slot frees
                  st_d = SDHP_DONE;
            end
         end
         default:
            st_d = SDHP_IDLE;
      endcase
      // output stage toward the descriptor store
      dval_d = dval_q;
      dwr_d = dwr_q;
      if (!dval_q || desc_wr_ready)
      begin
         dval_d = fifo_out_valid;
         dwr_d = fifo_out;
      end
   end

   // byte buffer between the serial side and the store
   sdhp_fifo #(
      .WIDTH(SDHP_ADDR_W + 8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(core_clk),
      .rst_n(rst_n),
      .in_data(fifo_in),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out),
      .out_valid(fifo_out_valid),
      .out_ready(!dval_q || desc_wr_ready)
   );

   // registers only, next values come from the process above
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sck_q <= '0;
         sel_q <= 3'h7;
         sdi_q <= '0;
         psel_q <= '0;
         dsel_q <= '0;
         prog_en_q <= 1'b0;
         shreg_q <= '0;
         cnt_q <= '0;
         st_q <= SDHP_IDLE;
         hid_q <= SDHP_HID_RESET;
         hid_upd_q <= 1'b0;
         addr_q <= '0;
         done_q <= 1'b0;
         dval_q <= 1'b0;
         dwr_q <= '0;
      end
      else
      begin
         sck_q <= sck_d;
         sel_q <= sel_d;
         sdi_q <= sdi_d;
         psel_q <= psel_d;
         dsel_q <= dsel_d;
         prog_en_q <= prog_en_d;
         shreg_q <= shreg_d;
         cnt_q <= cnt_d;
         st_q <= st_d;
         hid_q <= hid_d;
         hid_upd_q <= hid_upd_d;
         addr_q <= addr_d;
         done_q <= done_d;
         dval_q <= dval_d;
         dwr_q <= dwr_d;
      end
   end

   // every output straight from a flop
   assign hid_status = hid_q;
   assign hid_update = hid_upd_q;
   assign desc_addr = addr_q;
   assign desc_wr_valid = dval_q;
   assign desc_wr = dwr_q;
   assign desc_complete = done_q;
endmodule // sdhp_port

//--- sdhp_properties.sv
// Purpose: concurrent checks on the programming port outputs
// Assumes: source pins steady around each word
// Notes: bound to sdhp_port
`timescale 1ns/1ps
module sdhp_properties
   import sdhp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic word_select_strobe,
   input wire logic power_source_sel,
   input wire logic descriptor_source_sel,
   input wire logic [7:0] hid_status,
   input wire logic hid_update,
   input wire logic [SDHP_ADDR_W-1:0] desc_addr,
   input wire logic desc_wr_valid,
   input wire logic [SDHP_ADDR_W+7:0] desc_wr,
   input wire logic desc_wr_ready,
   input wire logic desc_complete
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence ptr_clear_s;
      $changed(desc_addr) && desc_addr == 6'h00;
   endsequence
   upd_pulse_a:
      assert property (hid_update |=> !hid_update) else $error("hid update too long");
   hid_load_a:
      assert property ($changed(hid_status) |-> hid_update) else $error("hid status moved");
   word_act_a:
      assert property (hid_update |-> $past(word_select_strobe, 3)) else $error("early act");
   wr_hold_a:
      assert property (desc_wr_valid && !desc_wr_ready |=> desc_wr_valid && $stable(desc_wr))
      else $error("write dropped");
   addr_step_a:
      assert property ($changed(desc_addr) |-> desc_addr == $past(desc_addr) + 6'h01
         || desc_addr == 6'h00) else $error("address jump");
   src_gate_a:
      assert property ($changed(desc_addr) |-> $past(power_source_sel && descriptor_source_sel, 4))
      else $error("write while gated");
   ptr_hid_a:
      assert property (ptr_clear_s |-> (hid_update || $past(hid_update)) or ##[1:2] hid_update)
      else $error("reset without hid");
   done_cnt_a:
      assert property ($rose(desc_complete) |-> desc_addr == 6'h38) else $error("early done");
   done_clear_a:
      assert property ($fell(desc_complete) |-> ptr_clear_s) else $error("done dropped");
endmodule // sdhp_properties

//--- sdhp_host.sv
// Purpose: spi host model driving the serial programming pins
// Assumes: 80 ns serial clock, idle low between words
// Notes: data shows inverse of last bit after a word
`timescale 1ns/1ps
module sdhp_host (
   output logic serial_clock_in,
   output logic serial_data_in,
   output logic word_select_strobe
);
   logic dp_pullup_en;
   initial
   begin
      serial_clock_in = 1'b0;
      serial_data_in = 1'b0;
      word_select_strobe = 1'b1;
      dp_pullup_en = 1'b0;
   end
   task automatic set_pullup(input logic on);
      dp_pullup_en = on;
   endtask
   task automatic send_bits(input logic [15:0] w, input int n);
      word_select_strobe = 1'b0;
      for (int i = 15; i > 15 - n; i--)
      begin
         serial_data_in = w[i];
         #40 serial_clock_in = 1'b1;
         #40 serial_clock_in = 1'b0;
      end
      #40 word_select_strobe = 1'b1;
      serial_data_in = ~w[16 - n];
      #300;
   endtask
   task automatic send_word(input logic [15:0] w);
      send_bits(w, 16);
   endtask
endmodule // sdhp_host

//--- test_serial_descriptor_hid_programming.sv
// Purpose: bench for the serial programming port
// Assumes: host model drives the serial pins
// Notes: descriptor byte n carries n xor 5A
`timescale 1ns/1ps
module test_serial_descriptor_hid_programming;
   import sdhp_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic power_source_sel = 1'b0;
   logic descriptor_source_sel = 1'b0;
   logic desc_wr_ready = 1'b0;
   wire serial_clock_in, serial_data_in, word_select_strobe;
   logic [7:0] hid_status;
   logic hid_update, desc_wr_valid, desc_complete;
   logic [SDHP_ADDR_W-1:0] desc_addr;
   logic [SDHP_ADDR_W+7:0] desc_wr;
   int errors = 0;
   int checks = 0;
   int cycles = 0;
   int hits = 0;
   int taken = 0;
   localparam int IMAGE_BYTES = 2 + 2 + 16 + 32 + 1 + 1 + 3;
   sdhp_port i_sdhp_port (.*);
   sdhp_host i_sdhp_host (.*);
   initial
   begin
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [15:0] word(input logic sel, input logic ptr, input logic [7:0] b);
      word = {4'h0, sel, 1'b0, ptr, 9'h000};
      for (int i = 0; i < 8; i++)
         word[7-i] = b[i];
   endfunction
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cycles++;
      if (hid_update === 1'b1)
         hits++;
      if (desc_wr_valid === 1'b1 && desc_wr_ready === 1'b1)
      begin
         check("desc_wr", {taken[5:0], taken[7:0] ^ 8'h5A}, 16'(desc_wr));
         taken++;
      end
      if (cycles == 20000)
      begin
         errors++;
         finish_test();
      end
   end
   task automatic hid_walk();
      for (int k = 0; k < 8; k++)
      begin
         i_sdhp_host.send_word(word(1'b0, 1'b0, 8'h01 << k));
         check("hid_status", 16'(8'h01 << k), 16'(hid_status));
         check("hid_update", 16'(k + 1), 16'(hits));
      end
      i_sdhp_host.send_bits(word(1'b0, 1'b0, 8'h3C), 12);
      check("short_hid", 16'h0080, 16'(hid_status));
      check("short_upd", 16'h0008, 16'(hits));
   endtask
   task automatic desc_prog();
      @(negedge core_clk);
      power_source_sel = 1'b1;
      descriptor_source_sel = 1'b1;
      i_sdhp_host.send_word(word(1'b0, 1'b1, 8'h81));
      check("hid_ptr", 16'h0081, 16'(hid_status));
      i_sdhp_host.send_word(word(1'b1, 1'b1, 8'hFF));
      check("reserved", 16'h0000, 16'(desc_addr));
      for (int n = 0; n < IMAGE_BYTES; n++)
      begin
         if (n == 18)
         begin
            check("fifo_full", 16'h0011, 16'(desc_addr));
            @(negedge core_clk);
            desc_wr_ready = 1'b1;
            repeat (4) @(negedge core_clk);
            check("stall_push", 16'h0012, 16'(desc_addr));
         end
         i_sdhp_host.send_word(word(1'b1, 1'b0, n[7:0] ^ 8'h5A));
      end
      i_sdhp_host.send_word(word(1'b1, 1'b0, 8'h11));
      check("complete", 16'h0001, 16'(desc_complete));
      check("taken", 16'h0039, 16'(taken));
      i_sdhp_host.set_pullup(desc_complete === 1'b1);
   endtask
   task automatic gate_off();
      @(negedge core_clk);
      power_source_sel = 1'b0;
      i_sdhp_host.send_word(word(1'b0, 1'b1, 8'hA5));
      check("gate_addr", 16'h0038, 16'(desc_addr));
      check("gate_hid", 16'h00A5, 16'(hid_status));
      @(negedge core_clk);
      power_source_sel = 1'b1;
      i_sdhp_host.set_pullup(1'b0);
      i_sdhp_host.send_word(word(1'b0, 1'b1, 8'h3C));
      check("reset_addr", 16'h0000, 16'(desc_addr));
      check("reset_done", 16'h0000, 16'(desc_complete));
      @(negedge core_clk);
      descriptor_source_sel = 1'b0;
      i_sdhp_host.send_word(word(1'b1, 1'b0, 8'h77));
      check("gate_byte", 16'h0000, 16'(desc_addr));
      check("gate_taken", 16'h0039, 16'(taken));
   endtask
   initial
   begin
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      hid_walk();
      desc_prog();
      gate_off();
      finish_test();
   end
endmodule // test_serial_descriptor_hid_programming
bind sdhp_port sdhp_properties i_sdhp_properties (.*);
